// [src/cfc_pkg.sv]
// constants, register map and types of the fault-confinement block
// assumes a 32-bit axi4-lite register bus and 8-bit error counters
package cfc_pkg;
  // error-state thresholds and counter figures
  localparam logic [7:0] CFC_WARN_LVL     = 8'h60; // 96
  localparam logic [7:0] CFC_PASS_LVL     = 8'h80; // 128
  localparam logic [7:0] CFC_BUS_OFF_FLAG_GUARD   = 8'hF8; // 248, +8 would overflow
  localparam logic [7:0] CFC_INC_BIG      = 8'h08;
  localparam logic [7:0] CFC_INC_SMALL    = 8'h01;
  localparam logic [7:0] CFC_CNT_MAX      = 8'hFF;
  localparam logic [2:0] CFC_FLAG_BITS    = 3'h6;
  localparam logic [3:0] CFC_SUSP_BITS    = 4'h8;
  localparam logic [3:0] CFC_IDLE_RUN     = 4'hB; // 11 recessive bits
  localparam logic [7:0] CFC_IDLE_SEQS    = 8'h80; // 128 runs
  // register byte addresses
  localparam logic [7:0] CFC_A_CTRL       = 8'h00;
  localparam logic [7:0] CFC_A_INFO       = 8'h04;
  localparam logic [7:0] CFC_A_ERRCNT     = 8'h08;
  localparam logic [7:0] CFC_A_IRQ_STAT   = 8'h0C;
  localparam logic [7:0] CFC_A_IRQ_MASK   = 8'h10;
  // info register bit positions
  localparam int CFC_B_RX_WARN  = 0;
  localparam int CFC_B_RX_PASS  = 1;
  localparam int CFC_B_TX_WARN  = 2;
  localparam int CFC_B_TX_PASS  = 3;
  localparam int CFC_B_BUS_OFF  = 4;
  // interrupt status bit positions
  localparam int CFC_I_WARN     = 0;
  localparam int CFC_I_PASSIVE  = 1;
  localparam int CFC_I_BUS_OFF  = 2;
  localparam int CFC_I_RECOVER  = 3;
  localparam int CFC_IRQ_W      = 4;
  // axi responses
  localparam logic [1:0] CFC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CFC_RESP_SLVERR = 2'h2;
  // error states
  typedef enum logic [1:0] {
    CFC_ACTIVE,
    CFC_PASSIVE,
    CFC_BUSOFF
  } cfc_state_t;
endpackage

// [src/cfc_fault_conf.sv]
// fault-confinement state of a can controller with axi4-lite registers
// assumes a protocol engine on the same clock giving error, ok and bit
// tick pulses; the bus receive level arrives from a pin and is synchronised
`timescale 1ns/10ps

module cfc_fault_conf (
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  // axi4-lite write channels
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  output logic [1:0]         s_axi_bresp,
  // axi4-lite read channels
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  input  wire logic [7:0]    s_axi_araddr,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  // protocol engine events
  input  wire logic          i_bit_tick,
  input  wire logic          i_err_detect,
  input  wire logic          i_tx_inc8,
  input  wire logic          i_rx_inc1,
  input  wire logic          i_rx_inc8,
  input  wire logic          i_ack_err,
  input  wire logic          i_delim_first,
  input  wire logic          i_tx_ok,
  input  wire logic          i_rx_ok,
  input  wire logic          i_intermission_end,
  // bus pin
  input  wire logic          i_rx_pin,
  // status towards the engine
  output logic               o_flag_drive,
  output logic               o_flag_level,
  output logic               o_tx_suspend,
  output logic               o_bus_off,
  output cfc_pkg::cfc_state_t o_state,
  output logic               o_irq
);
  import cfc_pkg::*;
  typedef struct packed {
    cfc_state_t              state;
    logic [7:0]              tx_error_counter;
    logic [7:0]              rx_error_counter;
    logic                    bus_off_flag;
    logic                    init_mode;
    logic                    init_seen;
    logic                    pend_tx8;
    logic                    pend_rx1;
    logic                    pend_rx8;
    logic                    ack_exc;
    logic                    dom_seen;
    logic                    flag_dom;
    logic [2:0]              flag_cnt;
    logic [3:0]              susp_cnt;
    logic [3:0]              run_cnt;
    logic [7:0]              seq_cnt;
    logic [CFC_IRQ_W-1:0]    irq_stat;
    logic [CFC_IRQ_W-1:0]    irq_mask;
    logic                    aw_got;
    logic [7:0]              aw_addr;
    logic                    w_got;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
    logic                    sync1;
    logic                    sync2;
  } cfc_st_t;
  cfc_st_t st_r;
  cfc_st_t st_nxt;
  // address decode used by read and write paths
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == CFC_A_CTRL) || (a == CFC_A_INFO) ||
              (a == CFC_A_ERRCNT) || (a == CFC_A_IRQ_STAT) ||
              (a == CFC_A_IRQ_MASK);
  endfunction
  // info word built from the counters and the bus-off flag
  function automatic logic [31:0] info_word(input cfc_st_t s);
    info_word = '0;
    info_word[CFC_B_RX_WARN] = (s.rx_error_counter >= CFC_WARN_LVL);
    info_word[CFC_B_RX_PASS] = (s.rx_error_counter >= CFC_PASS_LVL);
    info_word[CFC_B_TX_WARN] = (s.tx_error_counter >= CFC_WARN_LVL) || s.bus_off_flag;
    info_word[CFC_B_TX_PASS] = (s.tx_error_counter >= CFC_PASS_LVL) || s.bus_off_flag;
    info_word[CFC_B_BUS_OFF] = s.bus_off_flag;
  endfunction
  logic rx_recessive;
  logic wr_fire;
  logic [CFC_IRQ_W-1:0] irq_set;
  logic [31:0] info_now;
  logic [31:0] info_new;
  assign rx_recessive = st_r.sync2;
  assign wr_fire = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  // next-state logic of the whole block
  always_comb begin
    st_nxt = st_r;
    irq_set = '0;
    info_now = info_word(st_r);
    st_nxt.sync1 = i_rx_pin;
    st_nxt.sync2 = st_r.sync1;
    // flag start: type from the state before the error
    if (i_err_detect && !st_r.bus_off_flag) begin
      st_nxt.flag_cnt = CFC_FLAG_BITS;
      st_nxt.flag_dom = (st_r.state == CFC_ACTIVE);
      st_nxt.dom_seen = 1'b0;
    end else if (i_bit_tick && st_r.flag_cnt != '0) begin
      st_nxt.flag_cnt = st_r.flag_cnt - 3'h1;
      if (!rx_recessive)
        st_nxt.dom_seen = 1'b1;
    end
    // increments wait until the error delimiter
    if (i_tx_inc8) begin
      st_nxt.pend_tx8 = 1'b1;
      st_nxt.ack_exc = i_ack_err && (st_r.state == CFC_PASSIVE);
    end
    if (i_rx_inc1)
      st_nxt.pend_rx1 = 1'b1;
    if (i_rx_inc8)
      st_nxt.pend_rx8 = 1'b1;
    if (i_delim_first && !st_r.bus_off_flag) begin
      if (st_r.pend_tx8 && !(st_r.ack_exc && !st_r.dom_seen)) begin
        if (st_r.tx_error_counter >= CFC_BUS_OFF_FLAG_GUARD) begin
          st_nxt.bus_off_flag = 1'b1;
        end else begin
          st_nxt.tx_error_counter = st_r.tx_error_counter + CFC_INC_BIG;
        end
      end
      if (st_r.pend_rx8)
        st_nxt.rx_error_counter = (st_r.rx_error_counter > CFC_CNT_MAX - CFC_INC_BIG) ? CFC_CNT_MAX :
                     st_r.rx_error_counter + CFC_INC_BIG;
      else if (st_r.pend_rx1 && st_r.rx_error_counter != CFC_CNT_MAX)
        st_nxt.rx_error_counter = st_r.rx_error_counter + CFC_INC_SMALL;
      st_nxt.pend_tx8 = 1'b0;
      st_nxt.pend_rx1 = 1'b0;
      st_nxt.pend_rx8 = 1'b0;
      st_nxt.ack_exc = 1'b0;
    end else begin
      if (i_tx_ok && st_r.tx_error_counter != '0 && !st_r.bus_off_flag)
        st_nxt.tx_error_counter = st_r.tx_error_counter - CFC_INC_SMALL;
      if (i_rx_ok && st_r.rx_error_counter != '0)
        st_nxt.rx_error_counter = st_r.rx_error_counter - CFC_INC_SMALL;
    end
    // suspend transmission after intermission while passive
    if (i_intermission_end && st_r.state == CFC_PASSIVE)
      st_nxt.susp_cnt = CFC_SUSP_BITS;
    else if (i_bit_tick && st_r.susp_cnt != '0)
      st_nxt.susp_cnt = st_r.susp_cnt - 4'h1;
    // bus-off recovery: init mode, then 128 runs of 11 recessive bits
    if (!st_r.bus_off_flag) begin
      st_nxt.init_seen = 1'b0;
      st_nxt.run_cnt = '0;
      st_nxt.seq_cnt = '0;
    end else if (st_r.init_mode) begin
      st_nxt.init_seen = 1'b1;
      st_nxt.run_cnt = '0;
      st_nxt.seq_cnt = '0;
    end else if (st_r.init_seen && i_bit_tick) begin
      if (!rx_recessive) begin
        st_nxt.run_cnt = '0;
      end else if (st_r.run_cnt == CFC_IDLE_RUN - 4'h1) begin
        st_nxt.run_cnt = '0;
        st_nxt.seq_cnt = st_r.seq_cnt + 8'h01;
        if (st_r.seq_cnt == CFC_IDLE_SEQS - 8'h01) begin
          st_nxt.bus_off_flag = 1'b0;
          st_nxt.tx_error_counter = '0;
          st_nxt.rx_error_counter = '0;
          st_nxt.pend_tx8 = 1'b0;
          st_nxt.pend_rx1 = 1'b0;
          st_nxt.pend_rx8 = 1'b0;
          irq_set[CFC_I_RECOVER] = 1'b1;
        end
      end else begin
        st_nxt.run_cnt = st_r.run_cnt + 4'h1;
      end
    end
    if (st_nxt.bus_off_flag) begin
      st_nxt.flag_cnt = '0;
      st_nxt.susp_cnt = '0;
    end
    // error state from the new counters
    if (st_nxt.bus_off_flag)
      st_nxt.state = CFC_BUSOFF;
    else if (st_nxt.tx_error_counter >= CFC_PASS_LVL || st_nxt.rx_error_counter >= CFC_PASS_LVL)
      st_nxt.state = CFC_PASSIVE;
    else
      st_nxt.state = CFC_ACTIVE;
    // interrupt events on rising status bits
    info_new = info_word(st_nxt);
    irq_set[CFC_I_WARN] = (info_new[CFC_B_TX_WARN] &&
                           !info_now[CFC_B_TX_WARN]) ||
                          (info_new[CFC_B_RX_WARN] &&
                           !info_now[CFC_B_RX_WARN]);
    irq_set[CFC_I_PASSIVE] = (st_nxt.state == CFC_PASSIVE) &&
                             (st_r.state != CFC_PASSIVE);
    irq_set[CFC_I_BUS_OFF] = st_nxt.bus_off_flag && !st_r.bus_off_flag;
    // axi write: address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (wr_fire) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = addr_ok(st_r.aw_addr) ? CFC_RESP_OKAY : CFC_RESP_SLVERR;
      if (st_r.wstrb[0]) begin
        case (st_r.aw_addr)
          CFC_A_CTRL: st_nxt.init_mode = st_r.wdata[0];
          CFC_A_IRQ_STAT:
            st_nxt.irq_stat = st_r.irq_stat & ~st_r.wdata[CFC_IRQ_W-1:0];
          CFC_A_IRQ_MASK: st_nxt.irq_mask = st_r.wdata[CFC_IRQ_W-1:0];
          default: ;
        endcase
      end
    end else if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    // new events win over a clearing write
    st_nxt.irq_stat = st_nxt.irq_stat | irq_set;
    // axi read
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = addr_ok(s_axi_araddr) ? CFC_RESP_OKAY : CFC_RESP_SLVERR;
      case (s_axi_araddr)
        CFC_A_CTRL:     st_nxt.rdata = {31'h0, st_r.init_mode};
        CFC_A_INFO:     st_nxt.rdata = info_now;
        CFC_A_ERRCNT:   st_nxt.rdata = {16'h0, st_r.rx_error_counter, st_r.tx_error_counter};
        CFC_A_IRQ_STAT: st_nxt.rdata = {28'h0, st_r.irq_stat};
        CFC_A_IRQ_MASK: st_nxt.rdata = {28'h0, st_r.irq_mask};
        default:        st_nxt.rdata = 32'h0;
      endcase
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end
  // state register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= '0;
      st_r.state <= CFC_ACTIVE;
      st_r.sync1 <= 1'b1;
      st_r.sync2 <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end
  // outputs
  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready  = !st_r.w_got && !st_r.bvalid;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;
  assign o_flag_drive  = (st_r.flag_cnt != '0);
  assign o_flag_level  = !st_r.flag_dom; // 0 is dominant
  assign o_tx_suspend  = (st_r.susp_cnt != '0);
  assign o_bus_off     = st_r.bus_off_flag;
  assign o_state       = st_r.state;
  assign o_irq         = |(st_r.irq_stat & st_r.irq_mask);
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  tx_warn_lvl_a: assert property (st_r.tx_error_counter >= CFC_WARN_LVL |->
    info_now[CFC_B_TX_WARN]) else $error("tx warning missing");
  rx_warn_lvl_a: assert property (info_now[CFC_B_RX_WARN] ==
    (st_r.rx_error_counter >= CFC_WARN_LVL)) else $error("rx warning wrong");
  passive_state_a: assert property (!st_r.bus_off_flag &&
    (st_r.tx_error_counter >= CFC_PASS_LVL || st_r.rx_error_counter >= CFC_PASS_LVL) |->
    o_state == CFC_PASSIVE) else $error("passive not entered");
  bus_off_flag_guard_a: assert property (i_delim_first && !st_r.bus_off_flag &&
    st_r.pend_tx8 && !st_r.ack_exc && st_r.tx_error_counter >= CFC_BUS_OFF_FLAG_GUARD |=>
    o_bus_off && $stable(st_r.tx_error_counter)) else $error("overflow not bus-off");
  ack_exc_a: assert property (i_delim_first && !st_r.bus_off_flag &&
    st_r.ack_exc && !st_r.dom_seen && !i_tx_ok |=> $stable(st_r.tx_error_counter))
    else $error("passive ack error counted");
  active_flag_a: assert property (i_err_detect && !st_r.bus_off_flag &&
    o_state == CFC_ACTIVE |=> o_flag_drive && !o_flag_level)
    else $error("active flag not dominant");
  passive_flag_a: assert property (i_err_detect && !st_r.bus_off_flag &&
    o_state == CFC_PASSIVE |=> o_flag_drive && o_flag_level)
    else $error("passive flag not recessive");
  suspend_len_a: assert property (i_intermission_end &&
    o_state == CFC_PASSIVE |=> o_tx_suspend && st_r.susp_cnt == CFC_SUSP_BITS)
    else $error("suspend not started");
  recover_a: assert property ($fell(o_bus_off) |->
    st_r.tx_error_counter == '0 && st_r.rx_error_counter == '0 && o_state == CFC_ACTIVE)
    else $error("recovery left counts");
  tx_dec_a: assert property (i_tx_ok && !i_delim_first &&
    !st_r.bus_off_flag && st_r.tx_error_counter != '0 && !st_r.init_seen |=>
    st_r.tx_error_counter == $past(st_r.tx_error_counter) - 8'h01) else $error("tx count not lowered");
  delim_only_a: assert property (!$past(i_delim_first) &&
    !o_bus_off && $past(!o_bus_off) |-> st_r.tx_error_counter <= $past(st_r.tx_error_counter))
    else $error("tx count rose off delimiter");
  busoff_cov_c: cover property ($rose(o_bus_off));
  recover_cov_c: cover property ($fell(o_bus_off));
  passive_cov_c: cover property (o_state == CFC_PASSIVE && o_tx_suspend);
  irq_cov_c: cover property ($rose(o_irq));
endmodule // cfc_fault_conf

// [verif/cfc_can_node.sv]
// model of the other nodes on the shared can bus and of the bit timing
// assumes one clock; a bit time lasts TICK_DIV clocks
`timescale 1ns/10ps
module cfc_can_node #(
  parameter int TICK_DIV = 4
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // bench request and device flag
  input  wire logic i_dom_req,
  input  wire logic i_flag_drive,
  input  wire logic i_flag_level,
  // bit timing and bus level
  output logic      o_bit_tick,
  output logic      o_rx_level
);
  int div_r;
  // bit-time divider, one tick pulse per bit
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div_r <= 0;
    end else begin
      div_r <= (div_r == TICK_DIV - 1) ? 0 : div_r + 1;
    end
  end
  assign o_bit_tick = (div_r == TICK_DIV - 1);
  // wired-and bus with no acking node: only a bench request or the
  // device's own dominant flag pulls it low, else the pull-up wins
  assign o_rx_level = ~(i_dom_req | (i_flag_drive & ~i_flag_level));
endmodule // cfc_can_node

// [verif/cfc_fault_conf_bench.sv]
// self-checking bench of the fault-confinement block
// assumes cfc_pkg, the design and the bus node model are compiled first
`timescale 1ns/10ps
module cfc_fault_conf_bench;
  import cfc_pkg::*;
  logic i_clk = 1'b0, i_rst = 1'b1;
  logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd;
  logic awr, wr, bv, arr, rv;
  logic [1:0] br, rr;
  logic err = 0, tx8 = 0, rx1 = 0, rx8 = 0, ack = 0, dlm = 0;
  logic txok = 0, rxok = 0, ime = 0, dom = 0;
  logic tick, rxl, fdrv, flvl, susp, bus_off_flag, irq;
  cfc_state_t st;
  int fails = 0, n_tests = 0, cyc = 0;
  logic [31:0] rdat;
  logic [1:0] rsp, wrsp;
  int nt, k;
  logic lv;

  cfc_fault_conf dut_u (
    .i_clk(i_clk), .i_rst(i_rst),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .s_axi_rdata(rd), .s_axi_rresp(rr),
    .i_bit_tick(tick), .i_err_detect(err), .i_tx_inc8(tx8),
    .i_rx_inc1(rx1), .i_rx_inc8(rx8), .i_ack_err(ack),
    .i_delim_first(dlm), .i_tx_ok(txok), .i_rx_ok(rxok),
    .i_intermission_end(ime), .i_rx_pin(rxl),
    .o_flag_drive(fdrv), .o_flag_level(flvl), .o_tx_suspend(susp),
    .o_bus_off(bus_off_flag), .o_state(st), .o_irq(irq));
  cfc_can_node #(.TICK_DIV(4)) node_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_dom_req(dom),
    .i_flag_drive(fdrv), .i_flag_level(flvl),
    .o_bit_tick(tick), .o_rx_level(rxl));

  // 40 MHz clock and cycle ceiling against hangs
  initial begin
    forever #12.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge i_clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (!(bv === 1'b1 && bre));
    wrsp = br;
    bre <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge i_clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge i_clk);
      if (arv && arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rdat = rd;
    rsp = rr;
    rre <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string nm);
    axi_rd(a);
    chk(nm, e, rdat);
  endtask
  task automatic do_reset();
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
  endtask
  // one error: flag ticks counted, then first delimiter bit applies adds
  task automatic err_ev(input logic t8, r1, r8, ak);
    @(posedge i_clk iff tick);
    err <= 1'b1;
    tx8 <= t8;
    rx1 <= r1;
    rx8 <= r8;
    ack <= ak;
    @(posedge i_clk);
    {err, tx8, rx1, rx8, ack} <= 5'h00;
    @(posedge i_clk);
    nt = 0;
    k = 0;
    lv = flvl;
    while (fdrv === 1'b1 && k < 200) begin
      if (tick) nt++;
      @(posedge i_clk);
      k++;
    end
    dlm <= 1'b1;
    @(posedge i_clk);
    dlm <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask
  task automatic tx_ok_n(input int n);
    repeat (n) begin
      @(posedge i_clk);
      txok <= 1'b1;
      @(posedge i_clk);
      txok <= 1'b0;
    end
  endtask

  task automatic t_reset();
    rdc(CFC_A_INFO, 32'h0, "info");
    chk("info resp", CFC_RESP_OKAY, rsp);
    rdc(CFC_A_ERRCNT, 32'h0, "errcnt");
    rdc(8'h14, 32'h0, "unmapped data");
    chk("unmapped resp", CFC_RESP_SLVERR, rsp);
    axi_wr(8'h14, 32'hF);
    chk("unmapped wr resp", CFC_RESP_SLVERR, wrsp);
    axi_wr(CFC_A_IRQ_MASK, 32'hF);
    chk("mask wr resp", CFC_RESP_OKAY, wrsp);
    $display("test reset done");
  endtask
  task automatic t_active();
    err_ev(1, 0, 0, 0);
    chk("active flag ticks", 6, nt);
    chk("active flag level", 0, lv);
    rdc(CFC_A_ERRCNT, 32'h8, "tec plus 8");
    tx_ok_n(9);
    rdc(CFC_A_ERRCNT, 32'h0, "tec floor");
    $display("test active done");
  endtask
  task automatic t_rx();
    repeat (12) err_ev(0, 0, 1, 0);
    rdc(CFC_A_INFO, 32'h1, "rx warn");
    chk("irq warn", 1, irq);
    axi_wr(CFC_A_IRQ_STAT, 32'h1);
    chk("irq cleared", 0, irq);
    repeat (4) err_ev(0, 0, 1, 0);
    chk("flag from old count", 0, lv);
    rdc(CFC_A_INFO, 32'h3, "rx passive");
    chk("passive state", CFC_PASSIVE, st);
    err_ev(0, 1, 0, 0);
    chk("passive ticks", 6, nt);
    chk("passive level", 1, lv);
    rdc(CFC_A_ERRCNT, 32'h8100, "rec");
    @(posedge i_clk);
    rxok <= 1'b1;
    @(posedge i_clk);
    rxok <= 1'b0;
    rdc(CFC_A_ERRCNT, 32'h8000, "rec minus one");
    rdc(CFC_A_INFO, 32'h3, "still rx passive");
    do_reset();
    axi_wr(CFC_A_IRQ_MASK, 32'hF);
    $display("test rx done");
  endtask
  task automatic t_tx();
    repeat (16) err_ev(1, 0, 0, 0);
    rdc(CFC_A_INFO, 32'hC, "tx passive");
    @(posedge i_clk iff tick);
    ime <= 1'b1;
    @(posedge i_clk);
    ime <= 1'b0;
    @(posedge i_clk);
    nt = 0;
    for (k = 0; k < 200 && susp === 1'b1; k++) begin
      if (tick) nt++;
      @(posedge i_clk);
    end
    chk("suspend ticks", 8, nt);
    err_ev(1, 0, 0, 1);
    rdc(CFC_A_ERRCNT, 32'h80, "ack passive");
    repeat (15) err_ev(1, 0, 0, 0);
    chk("not yet off", 0, bus_off_flag);
    err_ev(1, 0, 0, 0);
    chk("bus off out", 1, bus_off_flag);
    chk("bus off state", CFC_BUSOFF, st);
    rdc(CFC_A_INFO, 32'h1C, "bus off info");
    axi_rd(CFC_A_ERRCNT);
    chk("tec kept", 32'hF8, rdat & 32'hFF);
    chk("rec in bus off", 32'h0, rdat & 32'hFF00);
    err_ev(1, 0, 0, 0);
    chk("no flag off", 0, nt);
    rdc(CFC_A_IRQ_STAT, 32'h7, "irq stat");
    $display("test tx done");
  endtask
  task automatic t_recover();
    axi_wr(CFC_A_IRQ_STAT, 32'hF);
    axi_wr(CFC_A_CTRL, 32'h1);
    axi_wr(CFC_A_CTRL, 32'h0);
    nt = 0;
    for (k = 0; k < 9000 && st === CFC_BUSOFF; k++) begin
      if (tick) nt++;
      dom <= (nt == 700);
      @(posedge i_clk);
    end
    dom <= 1'b0;
    chk("runs low", 1, nt >= 1408);
    chk("runs high", 1, nt <= 1424);
    chk("active again", CFC_ACTIVE, st);
    rdc(CFC_A_ERRCNT, 32'h0, "counts cleared");
    rdc(CFC_A_IRQ_STAT, 32'h8, "recover irq");
    $display("test recover done");
  endtask

  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    t_active();
    t_rx();
    t_tx();
    t_recover();
    finish_test();
  end
endmodule // cfc_fault_conf_bench
